/* design/operand_address_and_status_flags.v */
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "opaddr_status_defines.vh"

// Function
// - autoincrement: address from register, increment after fetch
// - increment one for bytes, two for words
// - symbolic: next word is operand address
// - indexed: next word plus register is address
// - register zero selects symbolic, never index
// - immediate: next word is operand value
// - jump: doubled signed displacement plus advanced counter
// - bit address: register twelve base plus displacement
// - status: flags, zero gap, four mask bits
// - logical greater: unsigned source above other operand
// - arithmetic greater: signed compare, else positive result
// - equal: compare, zero, masked test, input bit
// - carry: adder carry or last shifted bit
// - add/subtract overflow from operand/result signs
// - increment/decrement overflow from sign transitions
// - left shift sign change; 8000 negate overflow
// - divide overflow when divisor not above high
// - byte parity of result, or of source
// - multi-bit parity only for counts one to eight
// - trap instruction sets extended-operation flag
// - mask loaded from immediate or saved register
module operand_address_and_status_flags
(
   // clock and reset
   input wire mclk_in,
   input wire rst_in,
   // axi4-lite register slave
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // operand address generation
   input wire ag_start_in,
   input wire [1:0] ag_mode_in,
   input wire ag_immediate_in,
   input wire ag_byte_in,
   input wire [3:0] ag_reg_in,
   input wire [15:0] ag_reg_val_in,
   input wire [15:0] ag_ext_word_in,
   input wire ag_fetched_in,
   output reg ag_done_out,
   output reg [15:0] ag_addr_out,
   output reg ag_is_value_out,
   output reg ag_ext_used_out,
   output reg ag_wb_out,
   output reg [3:0] ag_wb_reg_out,
   output reg [15:0] ag_wb_val_out,
   // relative jump and bit-space address
   input wire rel_start_in,
   input wire [15:0] instr_in,
   input wire [15:0] pc_in,
   input wire [15:0] wr12_in,
   output reg rel_done_out,
   output reg [15:0] jump_pc_out,
   output reg [11:0] bit_addr_out,
   // status flag update
   input wire flag_en_in,
   input wire [4:0] flag_op_in,
   input wire flag_byte_in,
   input wire [15:0] src_in,
   input wire [15:0] dst_in,
   input wire [15:0] result_in,
   input wire carry_in,
   input wire shift_out_bit_in,
   input wire sign_changed_in,
   input wire bit_space_input_in,
   input wire [3:0] bit_count_in,
   input wire [15:0] immediate_operand_in,
   input wire [15:0] workspace_reg_fifteen_in,
   output wire [15:0] processor_status_word_out
);

   // -----------------------------------------------------------------
   // status word
   // -----------------------------------------------------------------
   reg [15:0] st_q;
   reg [15:0] st_d;
   reg [15:0] byte_sel;
   reg [15:0] s_m;
   reg [15:0] d_m;
   reg [15:0] r_m;
   reg s_gt_u;
   reg s_gt_s;
   reg bit_load_par;

   assign processor_status_word_out = st_q;

   // -----------------------------------------------------------------
   // register bus
   // -----------------------------------------------------------------
   reg aw_held_q;
   reg [3:0] aw_addr_q;
   reg w_held_q;
   reg [15:0] w_data_q;
   reg [1:0] w_strb_q;
   wire wr_fire;
   wire sw_st_wr;
   wire [15:0] sw_st_val;

   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign sw_st_wr = wr_fire && (aw_addr_q == `REG_STATUS);
   // reserved bits 4..8 of the word never store a one
   assign sw_st_val = {w_strb_q[1] ? w_data_q[15:8] : st_q[15:8],
                       w_strb_q[0] ? w_data_q[7:0] : st_q[7:0]}
                      & `STATUS_WR_MASK;

   always @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_held_q <= 1'b0;
         w_data_q <= 16'h0000;
         w_strb_q <= 2'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata[15:0];
            w_strb_q <= s_axi_wstrb[1:0];
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // only the status word is writable
            s_axi_bresp <= (aw_addr_q == `REG_STATUS) ? `RESP_OKAY :
                           `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case ({s_axi_araddr[3:2], 2'h0})
            `REG_STATUS: s_axi_rdata <= {16'h0000, st_q};
            `REG_LAST_ADDR: s_axi_rdata <= {16'h0000, ag_addr_out};
            `REG_JUMP: s_axi_rdata <= {16'h0000, jump_pc_out};
            `REG_BITADDR: s_axi_rdata <= {20'h00000, bit_addr_out};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // operand address generation
   // -----------------------------------------------------------------
   reg inc_pend_q;

   always @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         ag_done_out <= 1'b0;
         ag_addr_out <= 16'h0000;
         ag_is_value_out <= 1'b0;
         ag_ext_used_out <= 1'b0;
         ag_wb_out <= 1'b0;
         ag_wb_reg_out <= 4'h0;
         ag_wb_val_out <= 16'h0000;
         inc_pend_q <= 1'b0;
      end
      else
      begin
         ag_done_out <= ag_start_in;
         ag_wb_out <= 1'b0;
         // the increment waits for the fetch so the old pointer is used
         if (inc_pend_q && ag_fetched_in)
         begin
            ag_wb_out <= 1'b1;
            inc_pend_q <= 1'b0;
         end
         if (ag_start_in)
         begin
            ag_is_value_out <= 1'b0;
            ag_ext_used_out <= 1'b0;
            if (ag_immediate_in)
            begin
               ag_addr_out <= ag_ext_word_in;
               ag_is_value_out <= 1'b1;
               ag_ext_used_out <= 1'b1;
            end
            else
            begin
               case (ag_mode_in)
                  `AM_REG:
                  begin
                     ag_addr_out <= ag_reg_val_in;
                     ag_is_value_out <= 1'b1;
                  end
                  `AM_IND: ag_addr_out <= ag_reg_val_in;
                  `AM_SYMIDX:
                  begin
                     ag_ext_used_out <= 1'b1;
                     if (ag_reg_in == 4'h0)
                        ag_addr_out <= ag_ext_word_in;
                     else
                        ag_addr_out <= ag_ext_word_in + ag_reg_val_in;
                  end
                  default:
                  begin
                     ag_addr_out <= ag_reg_val_in;
                     inc_pend_q <= 1'b1;
                     ag_wb_reg_out <= ag_reg_in;
                     ag_wb_val_out <= ag_reg_val_in +
                        (ag_byte_in ? `INC_BYTE : `INC_WORD);
                  end
               endcase
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // relative jump and bit-space address
   // -----------------------------------------------------------------
   wire [7:0] disp;

   assign disp = instr_in[7:0];

   always @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         rel_done_out <= 1'b0;
         jump_pc_out <= 16'h0000;
         bit_addr_out <= 12'h000;
      end
      else
      begin
         rel_done_out <= rel_start_in;
         if (rel_start_in)
         begin
            jump_pc_out <= pc_in + {{7{disp[7]}}, disp, 1'b0};
            bit_addr_out <= wr12_in[12:1] + {{4{disp[7]}}, disp};
         end
      end
   end

   // -----------------------------------------------------------------
   // flag evaluation
   // -----------------------------------------------------------------
   always @*
   begin
      byte_sel = flag_byte_in ? 16'hFF00 : 16'hFFFF;
      s_m = src_in & byte_sel;
      d_m = dst_in & byte_sel;
      r_m = result_in & byte_sel;
      s_gt_u = s_m > d_m;
      s_gt_s = (s_m[15] != d_m[15]) ? !s_m[15] : (s_m > d_m);
      bit_load_par = (bit_count_in != 4'h0) && (bit_count_in <= 4'h8) &&
                     (^src_in[15:8]);
      st_d = st_q;
      if (sw_st_wr)
         st_d = sw_st_val;
      // a core update in the same cycle as a bus write takes priority
      if (flag_en_in)
      begin
         case (flag_op_in)
            `FOP_CMP, `FOP_CMPI:
            begin
               st_d[`LGT_BIT] = s_gt_u;
               st_d[`AGT_BIT] = s_gt_s;
               st_d[`EQ_BIT] = (s_m == d_m);
               if (flag_byte_in && flag_op_in == `FOP_CMP)
                  st_d[`PAR_BIT] = ^src_in[15:8];
            end
            `FOP_ABS, `FOP_NEG:
            begin
               if (flag_op_in == `FOP_ABS)
               begin
                  st_d[`LGT_BIT] = (s_m != 16'h0000);
                  st_d[`AGT_BIT] = !s_m[15] && (s_m != 16'h0000);
                  st_d[`EQ_BIT] = (s_m == 16'h0000);
               end
               else
               begin
                  st_d[`LGT_BIT] = (r_m != 16'h0000);
                  st_d[`AGT_BIT] = !r_m[15] && (r_m != 16'h0000);
                  st_d[`EQ_BIT] = (r_m == 16'h0000);
               end
               st_d[`CY_BIT] = carry_in;
               st_d[`OV_BIT] = (src_in == 16'h8000);
            end
            `FOP_ADD, `FOP_SUB, `FOP_INC, `FOP_DEC, `FOP_LOGIC,
            `FOP_SHIFT, `FOP_SLA:
            begin
               st_d[`LGT_BIT] = (r_m != 16'h0000);
               st_d[`AGT_BIT] = !r_m[15] && (r_m != 16'h0000);
               st_d[`EQ_BIT] = (r_m == 16'h0000);
               case (flag_op_in)
                  `FOP_ADD:
                  begin
                     st_d[`CY_BIT] = carry_in;
                     st_d[`OV_BIT] = (s_m[15] == d_m[15]) &&
                                     (r_m[15] != d_m[15]);
                  end
                  `FOP_SUB:
                  begin
                     st_d[`CY_BIT] = carry_in;
                     st_d[`OV_BIT] = (s_m[15] != d_m[15]) &&
                                     (r_m[15] != d_m[15]);
                  end
                  `FOP_INC:
                  begin
                     st_d[`CY_BIT] = carry_in;
                     st_d[`OV_BIT] = !src_in[15] && result_in[15];
                  end
                  `FOP_DEC:
                  begin
                     st_d[`CY_BIT] = carry_in;
                     st_d[`OV_BIT] = src_in[15] && !result_in[15];
                  end
                  `FOP_SHIFT:
                     st_d[`CY_BIT] = shift_out_bit_in;
                  `FOP_SLA:
                  begin
                     st_d[`CY_BIT] = shift_out_bit_in;
                     st_d[`OV_BIT] = sign_changed_in;
                  end
                  default:
                     st_d[`CY_BIT] = st_q[`CY_BIT];
               endcase
               if (flag_byte_in && flag_op_in != `FOP_SHIFT &&
                   flag_op_in != `FOP_SLA)
                  st_d[`PAR_BIT] = ^result_in[15:8];
            end
            `FOP_ONES:
               st_d[`EQ_BIT] = ((src_in & ~dst_in) == 16'h0000);
            `FOP_ZEROS:
               st_d[`EQ_BIT] = ((src_in & dst_in) == 16'h0000);
            `FOP_TBIT:
               st_d[`EQ_BIT] = bit_space_input_in;
            // dst is the high dividend word, src the divisor
            `FOP_DIV:
               st_d[`OV_BIT] = (src_in <= dst_in);
            `FOP_XOP:
               st_d[`XOP_BIT] = 1'b1;
            `FOP_LOAD_MASK_IMMEDIATE:
               st_d[`MASK_HI:`MASK_LO] =
                  immediate_operand_in[3:0];
            // restoring a context brings back the saved word, except the reserved gap bits, which stay zero
            `FOP_RETURN_FROM_CONTEXT:
               st_d = workspace_reg_fifteen_in & `STATUS_WR_MASK;
            `FOP_BITLS:
               st_d[`PAR_BIT] = bit_load_par;
            default:
               st_d = st_d;
         endcase
      end
   end

   always @(posedge mclk_in)
   begin
      if (rst_in)
         st_q <= `STATUS_RST;
      else
         st_q <= st_d;
   end

endmodule
`default_nettype wire

/* design/opaddr_status_defines.vh */
`ifndef OPADDR_STATUS_DEFINES_VH
`define OPADDR_STATUS_DEFINES_VH

// status word bit positions (flag 0 is the most significant bit)
`define LGT_BIT 15
`define AGT_BIT 14
`define EQ_BIT 13
`define CY_BIT 12
`define OV_BIT 11
`define PAR_BIT 10
`define XOP_BIT 9
`define MASK_HI 3
`define MASK_LO 0
`define STATUS_RST 16'h0000
`define STATUS_WR_MASK 16'hFE0F

// operand address modes (two-bit mode field)
`define AM_REG 2'h0
`define AM_IND 2'h1
`define AM_SYMIDX 2'h2
`define AM_AUTOINC 2'h3
`define INC_BYTE 16'h0001
`define INC_WORD 16'h0002

// flag operation classes
`define FOP_NONE 5'h00
`define FOP_CMP 5'h01
`define FOP_CMPI 5'h02
`define FOP_ABS 5'h03
`define FOP_ADD 5'h04
`define FOP_SUB 5'h05
`define FOP_INC 5'h06
`define FOP_DEC 5'h07
`define FOP_NEG 5'h08
`define FOP_LOGIC 5'h09
`define FOP_SHIFT 5'h0A
`define FOP_SLA 5'h0B
`define FOP_ONES 5'h0C
`define FOP_ZEROS 5'h0D
`define FOP_TBIT 5'h0E
`define FOP_DIV 5'h0F
`define FOP_XOP 5'h10
`define FOP_LOAD_MASK_IMMEDIATE 5'h11
`define FOP_RETURN_FROM_CONTEXT 5'h12
`define FOP_BITLS 5'h13

// register map (byte addresses)
`define REG_STATUS 4'h0
`define REG_LAST_ADDR 4'h4
`define REG_JUMP 4'h8
`define REG_BITADDR 4'hC
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* tb/opaddr_status_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module opaddr_status_checker
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // address generation
   input wire logic ag_start_in,
   input wire logic [1:0] ag_mode_in,
   input wire logic ag_immediate_in,
   input wire logic [3:0] ag_reg_in,
   input wire logic [15:0] ag_reg_val_in,
   input wire logic [15:0] ag_ext_word_in,
   input wire logic ag_done_out,
   input wire logic [15:0] ag_addr_out,
   input wire logic ag_wb_out,
   // relative addressing
   input wire logic rel_start_in,
   input wire logic [15:0] instr_in,
   input wire logic [15:0] pc_in,
   input wire logic [15:0] wr12_in,
   input wire logic [15:0] jump_pc_out,
   input wire logic [11:0] bit_addr_out,
   // status
   input wire logic flag_en_in,
   input wire logic [4:0] flag_op_in,
   input wire logic [15:0] immediate_operand_in,
   input wire logic [15:0] processor_status_word_out
);
   logic [15:0] disp_q;
   logic [11:0] base_q;
   logic [3:0] imm_q;
   wire logic ag_go = ag_start_in && !ag_immediate_in;
   // ---------------------------------------------
   // helper captures, one cycle behind the inputs
   // ---------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      disp_q <= {{8{instr_in[7]}}, instr_in[7:0]};
      base_q <= wr12_in[12:1];
      imm_q <= immediate_operand_in[3:0];
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_done_pulse: assert property (ag_start_in |=> ag_done_out)
      else $error("address done missing");
   a_autoinc_addr: assert property (ag_go && ag_mode_in == 2'h3 |=>
      ag_addr_out == $past(ag_reg_val_in) && !ag_wb_out)
      else $error("autoincrement address wrong");
   a_symbolic_addr: assert property (ag_go && ag_mode_in == 2'h2 &&
      ag_reg_in == 4'h0 |=> ag_addr_out == $past(ag_ext_word_in))
      else $error("symbolic address wrong");
   a_indexed_addr: assert property (ag_go && ag_mode_in == 2'h2 &&
      ag_reg_in != 4'h0 |=> ag_addr_out ==
      $past(ag_ext_word_in) + $past(ag_reg_val_in))
      else $error("indexed address wrong");
   a_immediate_value: assert property (ag_start_in && ag_immediate_in |=>
      ag_addr_out == $past(ag_ext_word_in))
      else $error("immediate value wrong");
   a_jump_target: assert property (rel_start_in |=>
      jump_pc_out == $past(pc_in) + {disp_q[14:0], 1'b0})
      else $error("jump target wrong");
   a_bit_address: assert property (rel_start_in |=>
      bit_addr_out == base_q + disp_q[11:0])
      else $error("bit address wrong");
   a_gap_zero: assert property (processor_status_word_out[8:4] == 5'h00)
      else $error("status gap not zero");
   a_trap_flag: assert property (flag_en_in && flag_op_in == 5'h10 |=>
      processor_status_word_out[9])
      else $error("trap flag not set");
   a_mask_load: assert property (flag_en_in && flag_op_in == 5'h11 |=>
      processor_status_word_out[3:0] == imm_q)
      else $error("mask not loaded");
   c_writeback: cover property (ag_wb_out);
   c_relative: cover property (rel_start_in);
   c_restore: cover property (flag_en_in && flag_op_in == 5'h12);
endmodule
bind operand_address_and_status_flags opaddr_status_checker chk_i (.*);
`default_nettype wire

/* tb/operand_address_and_status_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module operand_address_and_status_flags_tb_top;
   logic mclk_in, rst_in;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, t, u;
   logic [1:0] s_axi_bresp, s_axi_rresp, ag_mode_in;
   logic ag_start_in, ag_immediate_in, ag_byte_in, ag_fetched_in;
   logic ag_done_out, ag_is_value_out, ag_ext_used_out, ag_wb_out;
   logic [3:0] ag_reg_in, ag_wb_reg_out, bit_count_in;
   logic [15:0] ag_reg_val_in, ag_ext_word_in, ag_addr_out, ag_wb_val_out;
   logic rel_start_in, rel_done_out, flag_en_in, flag_byte_in, carry_in;
   logic [15:0] instr_in, pc_in, wr12_in, jump_pc_out, src_in, dst_in;
   logic [15:0] result_in, immediate_operand_in, workspace_reg_fifteen_in;
   logic [15:0] processor_status_word_out, exp_st;
   logic [11:0] bit_addr_out;
   logic [4:0] flag_op_in;
   logic shift_out_bit_in, sign_changed_in, bit_space_input_in;
   int n_fail, checked;
   operand_address_and_status_flags DUT (.*);
   initial
   begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected status after one flag update
   function automatic logic [15:0] mdl(input logic [4:0] op,
      input logic [15:0] s, d, r, x, input logic [3:0] a);
      logic [15:0] n, k;
      n = exp_st;
      k = d - s;
      if (op >= 5'h04 && op <= 5'h0B)
      begin
         n[15] = r != 16'h0000;
         n[14] = !r[15] && r != 16'h0000;
         n[13] = r == 16'h0000;
      end
      if (op >= 5'h03 && op <= 5'h08)
         n[12] = a[3];
      case (op)
         5'h01, 5'h02:
         begin
            n[15] = (s[15] && !d[15]) || (s[15] == d[15] && k[15]);
            n[14] = (!s[15] && d[15]) || (s[15] == d[15] && k[15]);
            n[13] = s == d;
         end
         5'h03:
         begin
            n[15] = s != 16'h0000;
            n[14] = !s[15] && s != 16'h0000;
            n[13] = s == 16'h0000;
            n[11] = s == 16'h8000;
         end
         5'h04: n[11] = s[15] == d[15] && r[15] != d[15];
         5'h05: n[11] = s[15] != d[15] && r[15] != d[15];
         5'h06: n[11] = !s[15] && r[15];
         5'h07: n[11] = s[15] && !r[15];
         5'h08: n[11] = s == 16'h8000;
         5'h0A: n[12] = a[2];
         5'h0B: n[12:11] = a[2:1];
         5'h0C: n[13] = (s & ~d) == 16'h0000;
         5'h0D: n[13] = (s & d) == 16'h0000;
         5'h0E: n[13] = a[0];
         5'h0F: n[11] = s <= d;
         5'h10: n[9] = 1'b1;
         5'h11: n[3:0] = x[3:0];
         5'h12: n = x & 16'hFE0F;
         5'h13: n[10] = a != 4'h0 && a <= 4'h8 && ^s[15:8];
         default: ;
      endcase
      // byte parity: compare judges the source, arithmetic the result
      if (flag_byte_in && op inside {5'h01, 5'h04, 5'h05})
         n[10] = (op == 5'h01) ? ^s[15:8] : ^r[15:8];
      return n;
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, got);
      checked++;
      if (ex !== got)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] sb, input logic [1:0] er);
      bit ta, tw;
      @(posedge mclk_in);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= sb;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(posedge mclk_in);
         if (s_axi_awready)
         begin
            ta = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready)
         begin
            tw = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid)
         @(posedge mclk_in);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask
   task automatic axr(input logic [3:0] a, input logic [31:0] ex);
      @(posedge mclk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk_in); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid)
         @(posedge mclk_in);
      s_axi_rready <= 1'b0;
      chk("rdata", ex, s_axi_rdata);
      chk("rresp", 32'h0, {30'h0, s_axi_rresp});
   endtask
   task automatic flg(input logic [4:0] op, input logic [15:0] s, d);
      logic [15:0] r, x;
      logic [31:0] q;
      q = rnd();
      x = q[15:0];
      q = rnd();
      r = q[15:0];
      case (op)
         5'h04: r = d + s;
         5'h05: r = d - s;
         5'h06: r = s + 16'h0001;
         5'h07: r = s - 16'h0001;
         5'h08: r = -s;
         default: ;
      endcase
      @(posedge mclk_in);
      flag_en_in <= 1'b1;
      flag_op_in <= op;
      {src_in, dst_in, result_in} <= {s, d, r};
      {immediate_operand_in, workspace_reg_fifteen_in} <= {x, x};
      {carry_in, shift_out_bit_in, sign_changed_in} <= q[19:17];
      {bit_space_input_in, bit_count_in} <= {q[16], q[19:16]};
      exp_st = mdl(op, s, d, r, x, q[19:16]);
      @(posedge mclk_in);
      flag_en_in <= 1'b0;
      @(negedge mclk_in);
      chk("status", {16'h0, exp_st}, {16'h0, processor_status_word_out});
   endtask
   task automatic agt(input logic [1:0] m, input logic im, b,
      input logic [3:0] rg, input logic [15:0] v, e);
      logic [15:0] ex;
      ex = im ? e : (m == 2'h2 ? (rg == 4'h0 ? e : e + v) : v);
      @(posedge mclk_in);
      {ag_start_in, ag_mode_in, ag_immediate_in, ag_byte_in} <=
         {1'b1, m, im, b};
      {ag_reg_in, ag_reg_val_in, ag_ext_word_in} <= {rg, v, e};
      @(posedge mclk_in);
      ag_start_in <= 1'b0;
      @(negedge mclk_in);
      chk("agen", {12'h0, 1'b1, 1'b0, im || m == 2'h0, im || m == 2'h2, ex},
         {12'h0, ag_done_out, ag_wb_out, ag_is_value_out, ag_ext_used_out,
         ag_addr_out});
      if (m == 2'h3 && !im)
      begin
         @(posedge mclk_in);
         ag_fetched_in <= 1'b1;
         @(posedge mclk_in);
         ag_fetched_in <= 1'b0;
         @(negedge mclk_in);
         chk("wback", {11'h0, 1'b1, rg, v + (b ? 16'h0001 : 16'h0002)},
            {11'h0, ag_wb_out, ag_wb_reg_out, ag_wb_val_out});
      end
   endtask
   task automatic rel(input logic [15:0] ins, p, w);
      logic [15:0] jp;
      logic [11:0] ba;
      jp = p + {{7{ins[7]}}, ins[7:0], 1'b0};
      ba = w[12:1] + {{4{ins[7]}}, ins[7:0]};
      @(posedge mclk_in);
      {rel_start_in, instr_in, pc_in, wr12_in} <= {1'b1, ins, p, w};
      @(posedge mclk_in);
      rel_start_in <= 1'b0;
      @(negedge mclk_in);
      chk("reldone", 32'h1, {31'h0, rel_done_out});
      chk("jump", {16'h0, jp}, {16'h0, jump_pc_out});
      chk("bitaddr", {20'h0, ba}, {20'h0, bit_addr_out});
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      seed = 32'h942F;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
      {s_axi_rready, ag_start_in, ag_mode_in, ag_immediate_in} = '0;
      {ag_byte_in, ag_reg_in, ag_reg_val_in, ag_ext_word_in} = '0;
      {ag_fetched_in, rel_start_in, instr_in, pc_in, wr12_in} = '0;
      {flag_en_in, flag_op_in, flag_byte_in, src_in, dst_in} = '0;
      {result_in, carry_in, shift_out_bit_in, sign_changed_in} = '0;
      {bit_space_input_in, bit_count_in, immediate_operand_in} = '0;
      workspace_reg_fifteen_in = '0;
      exp_st = 16'h0000;
      rst_in = 1'b1;
      repeat (16) @(posedge mclk_in);
      rst_in <= 1'b0;
      axr(4'h0, 32'h0);
      axw(4'h0, 32'hFFFF, 4'hF, 2'h0);
      axr(4'h0, 32'hFE0F);
      axw(4'h0, 32'h0, 4'h1, 2'h0);
      axw(4'h4, 32'hFFFF, 4'hF, 2'h2);
      axr(4'h0, 32'hFE00);
      exp_st = 16'hFE00;
      agt(2'h2, 1'b0, 1'b0, 4'h0, 16'h5555, 16'h2000);
      agt(2'h3, 1'b0, 1'b1, 4'h5, 16'hFFFF, 16'h0);
      for (int i = 0; i < 24; i++)
      begin
         t = rnd();
         u = rnd();
         agt(t[1:0], t[2] & t[3], t[8], t[7:4], u[15:0],
            u[31:16]);
      end
      agt(2'h2, 1'b0, 1'b0, 4'h3, 16'h0010, 16'h1000);
      axr(4'h4, 32'h1010);
      rel(16'h1080, 16'h0000, 16'h0000);
      rel(16'h107F, 16'hFFFE, 16'h1FFE);
      rel(16'h00FE, 16'h0100, 16'h0246);
      axr(4'h8, 32'h00FC);
      axr(4'hC, 32'h0121);
      flg(5'h04, 16'h0001, 16'h7FFF);
      flg(5'h08, 16'h8000, 16'h0);
      flg(5'h03, 16'h8000, 16'h0);
      flg(5'h0F, 16'h1234, 16'h1234);
      flg(5'h01, 16'hABCD, 16'hABCD);
      flg(5'h02, 16'h8000, 16'h7FFF);
      // low bytes kept zero so the byte masking leaves the model exact
      flag_byte_in <= 1'b1;
      flg(5'h01, 16'h0700, 16'h0500);
      flg(5'h04, 16'h0300, 16'h0100);
      flg(5'h05, 16'h0100, 16'h0700);
      flag_byte_in <= 1'b0;
      for (int i = 0; i < 95; i++)
      begin
         t = rnd();
         flg(5'(i % 20),
            t[15:0], t[31:16]);
      end
      axr(4'h0, {16'h0, exp_st});
      give_verdict();
   end
   initial
   begin
      repeat (5000) @(posedge mclk_in);
      n_fail++;
      $display("ERROR watchdog expected finish seen timeout");
      give_verdict();
   end
endmodule
`default_nettype wire
